/* File: core/alarm_monitor_output.v */
/*
 * Alarm supervision unit with APB register access, sixteen alarm channels,
 * ignition shutdown, event log strobe and one discrete alarm output.
 * Assumes quantity and status inputs come from logic on ref_clk_i.
 */
// What this block does
// - Sixteen configurable alarm channels, each assignable to the discrete output.
// - Per-channel function: unused, above or below threshold, warning, error.
// - Each channel stores its own threshold and hysteresis.
// - Alarm triggers only after condition held longer than its delay.
// - Shutdown option turns ignition off at once on trigger.
// - Latching option holds the output until acknowledged.
// - Without latching the output follows the live alarm.
// - Logging records an event on trigger and on acknowledge.
// - Per-alarm enable decides whether it drives the output.
// - Output polarity selectable normally open or normally closed.
`timescale 1ns/1ns
`default_nettype none
`include "alarm_monitor_regs.vh"

module alarm_monitor_output
#(
  parameter TICK_CYCLES = `ALM_TICK_CYCLES
)
(
  // Clock and reset
  input  wire                                  ref_clk_i,
  input  wire                                  rst_b_i,
  // APB slave
  input  wire                                  psel_i,
  input  wire                                  penable_i,
  input  wire                                  pwrite_i,
  input  wire [11:0]                           paddr_i,
  input  wire [31:0]                           pwdata_i,
  output wire [31:0]                           prdata_o,
  output wire                                  pready_o,
  output wire                                  pslverr_o,
  // Monitored quantities, one per channel, flattened
  input  wire [`ALM_CHANNELS*`ALM_QTY_W-1:0]   qty_i,
  input  wire                                  warning_i,
  input  wire                                  error_i,
  // Results
  output wire                                  alarm_discrete_output_o,
  output wire                                  ignition_off_o,
  output wire                                  event_strobe_o,
  output wire [5:0]                            event_code_o,
  output wire                                  irq_o
);

  localparam N = `ALM_CHANNELS;

  // Configuration storage
  reg  [11:0]            cfg_r    [0:N-1];
  reg  [`ALM_QTY_W-1:0]  thresh_r [0:N-1];
  reg  [`ALM_QTY_W-1:0]  hyst_r   [0:N-1];
  reg  [`ALM_DLY_W-1:0]  delay_r  [0:N-1];
  reg  [3:0]             sel_r;
  reg                    nc_r;
  reg  [N-1:0]           latch_r;
  reg  [N-1:0]           active_d_r;
  reg                    shut_r;
  reg  [3:0]             irq_stat_r;
  reg  [3:0]             irq_mask_r;
  reg                    ev_stb_r;
  reg  [5:0]             ev_code_r;
  reg  [31:0]            rdata_r;
  reg                    out_r;

  wire [N-1:0]           active;
  wire [N-1:0]           assigned;
  wire [N-1:0]           shut_en;
  wire [N-1:0]           log_en;
  wire [N-1:0]           rise;
  wire                   tick;
  wire                   wr;
  wire                   rd;
  wire [N-1:0]           ack_w;
  wire [N-1:0]           ev_trig;
  wire [N-1:0]           ev_ack;
  reg  [N-1:0]           ev_pend_r;
  reg  [5:0]             ev_pick;
  reg                    ev_found;
  integer                k;

  // Zero wait states: every access completes in its access phase
  assign wr        = psel_i && penable_i && pwrite_i;
  assign rd        = psel_i && penable_i && !pwrite_i;
  assign pready_o  = 1'b1;
  assign pslverr_o = 1'b0;
  assign prdata_o  = rdata_r;

  alarm_tick
  #(
    .TICK_CYCLES (TICK_CYCLES)
  )
  u_tick
  (
    .ref_clk_i (ref_clk_i),
    .rst_b_i   (rst_b_i),
    .tick_o    (tick)
  );

  assign ack_w = (wr && paddr_i == `ALM_OFS_ACK) ? pwdata_i[N-1:0] : {N{1'b0}};

  genvar g;
  generate
    for (g = 0; g < N; g = g + 1)
    begin : g_ch
      alarm_channel u_ch
      (
        .ref_clk_i (ref_clk_i),
        .rst_b_i   (rst_b_i),
        .func_i    (cfg_r[g][`ALM_CFG_FUNC_MSB:`ALM_CFG_FUNC_LSB]),
        .thresh_i  (thresh_r[g]),
        .hyst_i    (hyst_r[g]),
        .delay_i   (delay_r[g]),
        .qty_i     (qty_i[g*`ALM_QTY_W +: `ALM_QTY_W]),
        .warning_i (warning_i),
        .error_i   (error_i),
        .tick_i    (tick),
        .active_o  (active[g])
      );
      assign assigned[g] = cfg_r[g][`ALM_CFG_OUT_BIT];
      assign shut_en[g]  = cfg_r[g][`ALM_CFG_SHUT_BIT];
      assign log_en[g]   = cfg_r[g][`ALM_CFG_LOG_BIT];
      assign rise[g]     = active[g] && !active_d_r[g];
      assign ev_trig[g]  = rise[g] && log_en[g];
      assign ev_ack[g]   = ack_w[g] && log_en[g];

      always @(posedge ref_clk_i)
      begin
        if (!rst_b_i)
          latch_r[g] <= 1'b0;
        else if (rise[g] && cfg_r[g][`ALM_CFG_LATCH_BIT])
          latch_r[g] <= 1'b1;
        else if (ack_w[g])
          latch_r[g] <= 1'b0;
      end
    end
  endgenerate

  // Lowest pending channel is reported first
  always @*
  begin
    ev_pick  = 6'h00;
    ev_found = 1'b0;
    for (k = N - 1; k >= 0; k = k - 1)
    begin
      if (ev_pend_r[k])
      begin
        ev_pick  = k[5:0];
        ev_found = 1'b1;
      end
    end
  end

  always @(posedge ref_clk_i)
  begin
    if (!rst_b_i)
    begin
      active_d_r <= {N{1'b0}};
      shut_r     <= 1'b0;
      out_r      <= 1'b0;
      ev_pend_r  <= {N{1'b0}};
      ev_stb_r   <= 1'b0;
      ev_code_r  <= 6'h00;
      irq_stat_r <= 4'h0;
    end
    else
    begin
      active_d_r <= active;
      // Shutdown stays until reset; restart is a system decision
      if (|(rise & shut_en))
        shut_r <= 1'b1;
      out_r <= |(assigned & (active | latch_r));
      // One strobe per cycle; trigger and acknowledge share the channel code
      ev_stb_r <= ev_found;
      if (ev_found)
      begin
        ev_code_r <= ev_pick;
        ev_pend_r <= (ev_pend_r & ~({{(N-1){1'b0}}, 1'b1} << ev_pick[3:0]))
                     | ev_trig | ev_ack;
      end
      else
        ev_pend_r <= ev_pend_r | ev_trig | ev_ack;
      // Sticky events; a read clears, an event in the same cycle wins
      irq_stat_r <= ((rd && paddr_i == `ALM_OFS_IRQ_STAT) ? 4'h0 : irq_stat_r)
                    | {|(ev_trig | ev_ack), |(rise & shut_en), |ack_w, |rise};
    end
  end

  // Register writes
  always @(posedge ref_clk_i)
  begin
    if (!rst_b_i)
    begin
      sel_r      <= 4'h0;
      nc_r       <= 1'b0;
      irq_mask_r <= `ALM_IRQ_MASK_RST;
      for (k = 0; k < N; k = k + 1)
      begin
        cfg_r[k]    <= `ALM_CFG_RST;
        thresh_r[k] <= {`ALM_QTY_W{1'b0}};
        hyst_r[k]   <= {`ALM_QTY_W{1'b0}};
        delay_r[k]  <= {`ALM_DLY_W{1'b0}};
      end
    end
    else if (wr)
    begin
      case (paddr_i)
        `ALM_OFS_CTRL:     nc_r                 <= pwdata_i[`ALM_CTRL_NC_BIT];
        `ALM_OFS_IRQ_MASK: irq_mask_r           <= pwdata_i[3:0];
        `ALM_OFS_SEL:      sel_r                <= pwdata_i[3:0];
        `ALM_OFS_CFG:      cfg_r[sel_r]         <= pwdata_i[11:0];
        `ALM_OFS_THRESH:   thresh_r[sel_r]      <= pwdata_i[`ALM_QTY_W-1:0];
        `ALM_OFS_HYST:     hyst_r[sel_r]        <= pwdata_i[`ALM_QTY_W-1:0];
        `ALM_OFS_DELAY:    delay_r[sel_r]       <= pwdata_i[`ALM_DLY_W-1:0];
        default:           sel_r                <= sel_r;
      endcase
    end
  end

  // Read data, registered in the setup cycle so it is valid in access phase
  always @(posedge ref_clk_i)
  begin
    if (!rst_b_i)
      rdata_r <= 32'h0000_0000;
    else if (psel_i && !penable_i && !pwrite_i)
    begin
      case (paddr_i)
        `ALM_OFS_CTRL:     rdata_r <= {31'h0000_0000, nc_r};
        `ALM_OFS_STATUS:   rdata_r <= {shut_r, out_r, 14'h0000, active | latch_r};
        `ALM_OFS_IRQ_STAT: rdata_r <= {28'h000_0000, irq_stat_r};
        `ALM_OFS_IRQ_MASK: rdata_r <= {28'h000_0000, irq_mask_r};
        `ALM_OFS_EVENT:    rdata_r <= {16'h0000, latch_r};
        `ALM_OFS_SEL:      rdata_r <= {28'h000_0000, sel_r};
        `ALM_OFS_CFG:      rdata_r <= {20'h0_0000, cfg_r[sel_r]};
        `ALM_OFS_THRESH:   rdata_r <= {16'h0000, thresh_r[sel_r]};
        `ALM_OFS_HYST:     rdata_r <= {16'h0000, hyst_r[sel_r]};
        `ALM_OFS_DELAY:    rdata_r <= {16'h0000, delay_r[sel_r]};
        default:           rdata_r <= 32'h0000_0000;
      endcase
    end
  end

  // Normally closed: contact level inverted, so idle reads high
  assign alarm_discrete_output_o = out_r ^ nc_r;
  assign ignition_off_o          = shut_r;
  assign event_strobe_o          = ev_stb_r;
  assign event_code_o            = ev_code_r;
  assign irq_o                   = |(irq_stat_r & irq_mask_r);

endmodule
`default_nettype wire

/* File: core/alarm_monitor_regs.vh */
/*
 * Register offsets, field positions, reset values and timing counts of the
 * alarm supervision unit. Assumes inclusion by bare name from core/ files.
 */
`ifndef ALARM_MONITOR_REGS_VH
`define ALARM_MONITOR_REGS_VH

`define ALM_CHANNELS       16
`define ALM_QTY_W          16
`define ALM_DLY_W          16

// Global registers
`define ALM_OFS_CTRL       12'h000
`define ALM_OFS_STATUS     12'h004
`define ALM_OFS_IRQ_STAT   12'h008
`define ALM_OFS_IRQ_MASK   12'h00c
`define ALM_OFS_ACK        12'h010
`define ALM_OFS_EVENT      12'h014
`define ALM_OFS_SEL        12'h018
// Per-channel window, selected by ALM_OFS_SEL
`define ALM_OFS_CFG        12'h020
`define ALM_OFS_THRESH     12'h024
`define ALM_OFS_HYST       12'h028
`define ALM_OFS_DELAY      12'h02c

// Control register fields
`define ALM_CTRL_NC_BIT    0

// Channel config fields
`define ALM_CFG_FUNC_LSB   0
`define ALM_CFG_FUNC_MSB   4
`define ALM_CFG_SHUT_BIT   8
`define ALM_CFG_LATCH_BIT  9
`define ALM_CFG_LOG_BIT    10
`define ALM_CFG_OUT_BIT    11

// Function codes
`define ALM_FN_UNUSED      5'h00
`define ALM_FN_ABOVE       5'h01
`define ALM_FN_BELOW       5'h02
`define ALM_FN_WARNING     5'h03
`define ALM_FN_ERROR       5'h04

// Interrupt status bit positions
`define ALM_IRQ_TRIG_BIT   0
`define ALM_IRQ_ACK_BIT    1
`define ALM_IRQ_SHUT_BIT   2
`define ALM_IRQ_EVOVF_BIT  3

// Reset values
`define ALM_CTRL_RST       32'h0000_0000
`define ALM_CFG_RST        12'h000
`define ALM_IRQ_MASK_RST   4'h0

// Delay counted in milliseconds: 25 MHz clock, 1 ms tick
`define ALM_CLK_HZ         25000000
`define ALM_TICK_MS        1
`define ALM_TICK_CYCLES    ((`ALM_CLK_HZ / 1000) * `ALM_TICK_MS)

`endif

/* File: core/alarm_channel.v */
/*
 * One alarm channel: source selection, threshold with hysteresis, and
 * qualification delay counted in ms ticks. Assumes quantities are already
 * on ref_clk_i and the tick is a one-cycle pulse on the same clock.
 */
`timescale 1ns/1ns
`default_nettype none
`include "alarm_monitor_regs.vh"

module alarm_channel
(
  // Clock and reset
  input  wire                    ref_clk_i,
  input  wire                    rst_b_i,
  // Configuration
  input  wire [4:0]              func_i,
  input  wire [`ALM_QTY_W-1:0]   thresh_i,
  input  wire [`ALM_QTY_W-1:0]   hyst_i,
  input  wire [`ALM_DLY_W-1:0]   delay_i,
  // Monitored state
  input  wire [`ALM_QTY_W-1:0]   qty_i,
  input  wire                    warning_i,
  input  wire                    error_i,
  input  wire                    tick_i,
  // Result
  output wire                    active_o
);

  reg  [`ALM_DLY_W-1:0] dly_cnt_r;
  reg                   active_r;
  reg                   cond;
  reg                   clear;
  wire [`ALM_QTY_W:0]   up_lim;
  wire [`ALM_QTY_W:0]   dn_lim;

  assign up_lim = {1'b0, thresh_i} + {1'b0, hyst_i};
  assign dn_lim = {1'b0, thresh_i} - {1'b0, hyst_i};

  always @*
  begin
    cond  = 1'b0;
    clear = 1'b1;
    case (func_i)
      `ALM_FN_ABOVE:
      begin
        cond  = qty_i > thresh_i;
        // Must fall hysteresis below the threshold
        clear = dn_lim[`ALM_QTY_W] || ({1'b0, qty_i} <= dn_lim);
      end
      `ALM_FN_BELOW:
      begin
        cond  = qty_i < thresh_i;
        clear = {1'b0, qty_i} >= up_lim;
      end
      `ALM_FN_WARNING:
      begin
        cond  = warning_i;
        clear = !warning_i;
      end
      `ALM_FN_ERROR:
      begin
        cond  = error_i;
        clear = !error_i;
      end
      default:
      begin
        cond  = 1'b0;
        clear = 1'b1;
      end
    endcase
  end

  always @(posedge ref_clk_i)
  begin
    if (!rst_b_i)
    begin
      dly_cnt_r <= {`ALM_DLY_W{1'b0}};
      active_r  <= 1'b0;
    end
    else if (active_r)
    begin
      dly_cnt_r <= {`ALM_DLY_W{1'b0}};
      if (clear)
        active_r <= 1'b0;
    end
    else if (!cond)
      dly_cnt_r <= {`ALM_DLY_W{1'b0}};
    else if (tick_i)
    begin
      // Trigger only once held longer than the delay
      if (dly_cnt_r >= delay_i)
        active_r <= 1'b1;
      else
        dly_cnt_r <= dly_cnt_r + {{(`ALM_DLY_W-1){1'b0}}, 1'b1};
    end
  end

  assign active_o = active_r;

endmodule
`default_nettype wire

/* File: core/alarm_tick.v */
/*
 * Millisecond tick generator. Assumes one free running ref_clk_i.
 */
`timescale 1ns/1ns
`default_nettype none
`include "alarm_monitor_regs.vh"

module alarm_tick
#(
  parameter TICK_CYCLES = `ALM_TICK_CYCLES
)
(
  // Clock and reset
  input  wire ref_clk_i,
  input  wire rst_b_i,
  // Tick
  output wire tick_o
);

  reg [15:0] cnt_r;
  reg        tick_r;

  always @(posedge ref_clk_i)
  begin
    if (!rst_b_i)
    begin
      cnt_r  <= 16'h0000;
      tick_r <= 1'b0;
    end
    else if (cnt_r == TICK_CYCLES[15:0] - 16'h0001)
    begin
      cnt_r  <= 16'h0000;
      tick_r <= 1'b1;
    end
    else
    begin
      cnt_r  <= cnt_r + 16'h0001;
      tick_r <= 1'b0;
    end
  end

  assign tick_o = tick_r;

endmodule
`default_nettype wire

/* File: testbench/alarm_monitor_output_asserts.sv */
/*
 * Port checker for the alarm supervision unit.
 * Assumes a bind from the bench top, one clock, sync active-low reset.
 */
`timescale 1ns/1ns
`default_nettype none
module alarm_monitor_output_asserts
(
  // Clock and reset
  input wire logic        ref_clk_i,
  input wire logic        rst_b_i,
  // APB
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  // Results
  input wire logic        alarm_discrete_output_o,
  input wire logic        ignition_off_o,
  input wire logic        event_strobe_o,
  input wire logic [5:0]  event_code_o,
  input wire logic        irq_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);

  sequence s_setup;
    psel_i && !penable_i;
  endsequence
  sequence s_access;
    psel_i && penable_i;
  endsequence

  property p_acc_ready;
    s_setup ##1 s_access |-> pready_o;
  endproperty
  a_acc_ready: assert property (p_acc_ready) else $error("access not ready");

  property p_no_err;
    !pslverr_o;
  endproperty
  a_no_err: assert property (p_no_err) else $error("slave error raised");

  property p_ign_sticky;
    ignition_off_o |=> ignition_off_o;
  endproperty
  a_ign_sticky: assert property (p_ign_sticky) else $error("ignition off dropped");

  property p_rst_quiet;
    $rose(rst_b_i) |-> !(ignition_off_o | alarm_discrete_output_o | irq_o | event_strobe_o);
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("outputs busy after reset");

  property p_rd_hold;
    $changed(prdata_o) |-> $past(psel_i && !penable_i && !pwrite_i);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");

  property p_irq_fall;
    $fell(irq_o) |-> $past(psel_i && penable_i && ((paddr_i == 12'h008 && !pwrite_i)
      || (paddr_i == 12'h00c && pwrite_i)));
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq fell without clear");

  property p_code_hold;
    $changed(event_code_o) |-> event_strobe_o;
  endproperty
  a_code_hold: assert property (p_code_hold) else $error("event code moved alone");

  property p_code_range;
    event_strobe_o |-> event_code_o < 6'h10;
  endproperty
  a_code_range: assert property (p_code_range) else $error("event code out of range");
endmodule
`default_nettype wire

/* File: testbench/alarm_reader.sv */
/*
 * Far-side equipment reading the discrete alarm output.
 * Assumes the bench tells it which polarity is configured.
 */
`timescale 1ns/1ns
`default_nettype none
module alarm_reader
(
  input  wire logic ref_clk_i,
  input  wire logic line_i,
  input  wire logic nc_i,
  output var logic  alarm_seen_o
);
  // One input flop, as a real input stage
  always @(posedge ref_clk_i)
  begin
    alarm_seen_o <= line_i ^ nc_i;
  end
endmodule
`default_nettype wire

/* File: testbench/alarm_monitor_output_tb.sv */
/*
 * Self-checking bench for the alarm supervision unit.
 * Assumes TICK_CYCLES shortened to 10 and zero-wait APB.
 */
`timescale 1ns/1ns
`default_nettype none
module alarm_monitor_output_tb;
  logic         ref_clk_i = 1'b0;
  logic         rst_b_i = 1'b0;
  logic         psel_i = 1'b0;
  logic         penable_i = 1'b0;
  logic         pwrite_i = 1'b0;
  logic [11:0]  paddr_i = 12'h000;
  logic [31:0]  pwdata_i = 32'h0;
  logic [31:0]  prdata_o;
  logic         pready_o;
  logic         pslverr_o;
  logic [255:0] qty_i = 256'h0;
  logic         warning_i = 1'b0;
  logic         error_i = 1'b0;
  logic         alarm_discrete_output_o;
  logic         ignition_off_o;
  logic         event_strobe_o;
  logic [5:0]   event_code_o;
  logic         irq_o;
  logic         nc = 1'b0;
  logic         seen;
  int           n_errors = 0;
  int           n_checks = 0;

  alarm_monitor_output #(.TICK_CYCLES(10)) DUT (.ref_clk_i, .rst_b_i, .psel_i, .penable_i,
    .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .qty_i, .warning_i,
    .error_i, .alarm_discrete_output_o, .ignition_off_o, .event_strobe_o, .event_code_o, .irq_o);
  alarm_reader u_rd (.ref_clk_i, .line_i(alarm_discrete_output_o), .nc_i(nc), .alarm_seen_o(seen));

  initial
  begin
    forever #20 ref_clk_i = ~ref_clk_i;
  end

  task automatic final_report();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic chkb(input string nm, input logic got, input logic exp);
    chk(nm, {31'h0, got}, {31'h0, exp});
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask

  // Waits an edge first, so back-to-back calls never assign twice in one step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge ref_clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge ref_clk_i);
    penable_i <= 1'b1;
    @(posedge ref_clk_i);
    while (pready_o !== 1'b1)
      @(posedge ref_clk_i);
    q = prdata_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask
  task automatic rd_chk(input string nm, input logic [11:0] a, input logic [31:0] e);
    logic [31:0] q;
    apb(1'b0, a, 32'h0, q);
    chk(nm, q, e);
  endtask
  task automatic cfg(input logic [3:0] ch, input logic [11:0] c, input logic [15:0] th,
                     input logic [15:0] hy, input logic [15:0] dl);
    wr(12'h018, {28'h0, ch});
    wr(12'h024, {16'h0, th});
    wr(12'h028, {16'h0, hy});
    wr(12'h02c, {16'h0, dl});
    wr(12'h020, {20'h0, c});
  endtask
  task automatic set_qty(input int ch, input logic [15:0] v);
    @(posedge ref_clk_i);
    qty_i[ch*16 +: 16] <= v;
  endtask
  task automatic wait_seen(input logic e, input int lim);
    int n;
    n = 0;
    while (seen !== e && n < lim)
    begin
      @(negedge ref_clk_i);
      n++;
    end
  endtask
  task automatic wait_strobe(output logic [5:0] code);
    int n;
    n = 0;
    code = 6'h3f;
    while (event_strobe_o !== 1'b1 && n < 60)
    begin
      @(negedge ref_clk_i);
      n++;
    end
    if (event_strobe_o === 1'b1)
      code = event_code_o;
  endtask

  task automatic t_regs();
    rd_chk("ctrl", 12'h000, 32'h0);
    rd_chk("mask", 12'h00c, 32'h0);
    wr(12'h100, 32'hffff_ffff);
    rd_chk("unmapped", 12'h100, 32'h0);
    cfg(4'h3, 12'h000, 16'h1234, 16'h0011, 16'h0000);
    cfg(4'hf, 12'h000, 16'h5678, 16'h0022, 16'h0000);
    wr(12'h018, 32'h3);
    rd_chk("thresh3", 12'h024, 32'h1234);
    rd_chk("hyst3", 12'h028, 32'h0011);
    wr(12'h018, 32'hf);
    rd_chk("thresh15", 12'h024, 32'h5678);
  endtask

  task automatic t_delay();
    cfg(4'h0, 12'h801, 16'h0064, 16'h000a, 16'h0003);
    set_qty(0, 16'h0096);
    cyc(20);
    set_qty(0, 16'h0000);
    cyc(60);
    chkb("short pulse", seen, 1'b0);
    set_qty(0, 16'h0096);
    cyc(25);
    chkb("before delay", seen, 1'b0);
    wait_seen(1'b1, 60);
    chkb("trigger", seen, 1'b1);
    set_qty(0, 16'h005f);
    cyc(30);
    chkb("in hysteresis", seen, 1'b1);
    set_qty(0, 16'h0055);
    wait_seen(1'b0, 10);
    chkb("cleared", seen, 1'b0);
    wr(12'h000, 32'h1);
    nc = 1'b1;
    cyc(2);
    chkb("nc idle level", alarm_discrete_output_o, 1'b1);
    chkb("nc seen", seen, 1'b0);
    wr(12'h000, 32'h0);
    nc = 1'b0;
  endtask

  task automatic t_assign();
    cfg(4'h8, 12'h001, 16'h0000, 16'h0000, 16'h0000);
    cfg(4'h9, 12'h800, 16'h0000, 16'h0000, 16'h0000);
    set_qty(8, 16'h0010);
    set_qty(9, 16'h0010);
    cyc(40);
    chkb("unassigned", seen, 1'b0);
    rd_chk("status", 12'h004, 32'h0000_0100);
    set_qty(8, 16'h0000);
  endtask

  task automatic t_funcs();
    cfg(4'h7, 12'h803, 16'h0000, 16'h0000, 16'h0000);
    cfg(4'h6, 12'h804, 16'h0000, 16'h0000, 16'h0000);
    for (int i = 0; i < 2; i++)
    begin
      @(posedge ref_clk_i);
      warning_i <= (i == 0);
      error_i <= (i == 1);
      wait_seen(1'b1, 40);
      chkb("status input", seen, 1'b1);
      @(posedge ref_clk_i);
      warning_i <= 1'b0;
      error_i <= 1'b0;
      wait_seen(1'b0, 40);
      chkb("status gone", seen, 1'b0);
    end
  endtask

  task automatic t_latch();
    logic [5:0] code;
    wr(12'h00c, 32'h1);
    set_qty(5, 16'h0064);
    cfg(4'h5, 12'hf02, 16'h0032, 16'h0000, 16'h0000);
    set_qty(5, 16'h000a);
    wait_strobe(code);
    chk("trig code", {26'h0, code}, 32'h5);
    chkb("ignition off", ignition_off_o, 1'b1);
    wait_seen(1'b1, 10);
    chkb("latched on", seen, 1'b1);
    chkb("irq", irq_o, 1'b1);
    rd_chk("irq stat", 12'h008, 32'h0000_000d);
    cyc(2);
    chkb("irq cleared", irq_o, 1'b0);
    set_qty(5, 16'h0064);
    cyc(30);
    chkb("latch holds", seen, 1'b1);
    wr(12'h010, 32'h0000_0020);
    wait_strobe(code);
    chk("ack code", {26'h0, code}, 32'h5);
    wait_seen(1'b0, 10);
    chkb("acked", seen, 1'b0);
    chkb("ignition stays", ignition_off_o, 1'b1);
  endtask

  initial
  begin
    repeat (3) @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    t_regs();
    t_delay();
    t_assign();
    t_funcs();
    t_latch();
    final_report();
  end

  // Whole run is a few hundred cycles
  initial
  begin
    repeat (20000) @(posedge ref_clk_i);
    n_errors++;
    final_report();
  end
endmodule

bind alarm_monitor_output alarm_monitor_output_asserts u_chk (.ref_clk_i, .rst_b_i, .psel_i,
  .penable_i, .pwrite_i, .paddr_i, .prdata_o, .pready_o, .pslverr_o, .alarm_discrete_output_o,
  .ignition_off_o, .event_strobe_o, .event_code_o, .irq_o);
`default_nettype wire
